//--- hw/sbsd_rate_gen.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// bit_rate_generator: one tick every divisor+1 clocks (16x bit rate)
// ------------------------------------------------------------------
module sbsd_rate_gen #(
  parameter int W = 8                     // divisor width
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] divisor,     // reload value
  output logic              tick         // one-cycle pulse
);

  logic [W-1:0] cnt_reg;                  // down counter

  // count down, reload and pulse at zero
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (cnt_reg == '0) begin
      cnt_reg <= divisor;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 1'b1;
      tick    <= 1'b0;
    end
  end

endmodule

//--- hw/sbsd_top.sv
`timescale 1ns/1ps

module sbsd_top #(
  parameter int RATE_W = 8                // divisor width
) (
  input  wire logic       MCLK,
  input  wire logic       RST,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       RXD,
  output logic            TXD,
  output logic            IRQ
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int IRQ_BITS_W = sbsd_pkg::IRQ_BITS;  // sticky event count

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } sbsd_rx_state_e;

  logic [RATE_W-1:0]   rate_reg;          // divisor for the rate generator
  logic                tick;              // 16x bit-rate tick
  logic                send_break_reg;    // send_break_ctl
  logic                tx_en_reg;         // transmit_enable_bit
  logic                rx_en_reg;         // receiver enable
  logic                wake_en_reg;       // auto wake-up armed
  logic                rate_det_reg;      // auto_rate_detect_enable
  logic [7:0]          tx_buf_reg;        // transmit_data_reg holding byte
  logic                tx_full_reg;       // buffer holds a byte
  logic                tx_busy_reg;       // shifter active
  logic                tx_brk_reg;        // current frame is a break
  logic [13:0]         tx_shift_reg;      // frame bits, lsb first
  logic [3:0]          tx_bit_reg;        // bit index within frame
  logic [3:0]          tx_tick_reg;       // tick within bit
  logic                txd_reg;           // line driver
  logic                tx_load;           // buffer moves to shifter
  logic                tx_done;           // last bit time ends
  logic [3:0]          tx_bits;           // frame length
  logic                rx_s1_reg;         // synchroniser first stage
  logic                rx_s2_reg;         // synchronised line
  logic                rx_prev_reg;       // previous synchronised level
  sbsd_rx_state_e      rx_state_reg;      // receiver state
  logic [3:0]          rx_tick_reg;       // tick within bit
  logic [2:0]          rx_bit_reg;        // data bit index
  logic [7:0]          rx_shift_reg;      // assembling byte
  logic [7:0]          rx_data_reg;       // receive_data_reg
  logic                rx_full_reg;       // byte waiting
  logic                rx_framing_error_flag_reg;       // framing_error_flag
  logic                wake_pend_reg;     // wake event waiting
  logic [1:0]          wake_cnt_reg;      // transitions seen while armed
  logic                rx_edge;           // line changed
  logic                wake_hit;          // second transition seen
  logic                rx_done;           // stop bit sampled
  logic [IRQ_BITS_W-1:0] irq_stat_reg;    // sticky event bits
  logic [IRQ_BITS_W-1:0] irq_mask_reg;    // event enables
  logic [IRQ_BITS_W-1:0] irq_set;         // events this cycle
  logic                wr_tx_data;        // software write of transmit byte
  logic                rd_rx_data;        // software read of received byte

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign wr_tx_data = WR && (ADDR == sbsd_pkg::ADDR_TX_DATA);
  assign rd_rx_data = RD && (ADDR == sbsd_pkg::ADDR_RX_DATA);

  // ----------------------------------------------------------------
  // rate generator
  // ----------------------------------------------------------------
  sbsd_rate_gen #(
    .W       (RATE_W)
  ) u_rate (
    .clk     (MCLK),
    .rst     (RST),
    .divisor (rate_reg),
    .tick    (tick)
  );

  // divisor register
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rate_reg <= RATE_W'(sbsd_pkg::RATE_RESET);
    end else if (WR && ADDR == sbsd_pkg::ADDR_RATE) begin
      rate_reg <= RATE_W'(WDATA);
    end
  end

  // ----------------------------------------------------------------
  // transmit control bits
  // ----------------------------------------------------------------
  // hardware clear of send-break wins over a same-cycle software write
  always_ff @(posedge MCLK) begin
    if (RST) begin
      send_break_reg <= 1'b0;
      tx_en_reg      <= 1'b0;
    end else begin
      if (WR && ADDR == sbsd_pkg::ADDR_TX_CTRL) begin
        send_break_reg <= WDATA[sbsd_pkg::TXC_SEND_BREAK];
        tx_en_reg      <= WDATA[sbsd_pkg::TXC_TX_ENABLE];
      end
      if (tx_done && tx_brk_reg) begin
        send_break_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit buffer
  // ----------------------------------------------------------------
  // shifter takes the buffer when idle and enabled
  assign tx_load = tx_full_reg && !tx_busy_reg && tx_en_reg;
  assign tx_bits = tx_brk_reg ? sbsd_pkg::BREAK_BITS : sbsd_pkg::NORMAL_BITS;
  assign tx_done = tx_busy_reg && tick && (tx_tick_reg == sbsd_pkg::OVERSAMPLE_LAST)
                   && (tx_bit_reg == tx_bits - 4'h1);

  // one-byte holding buffer; a write while full is dropped
  always_ff @(posedge MCLK) begin
    if (RST) begin
      tx_buf_reg  <= 8'h00;
      tx_full_reg <= 1'b0;
    end else if (tx_load) begin
      tx_full_reg <= 1'b0;
    end else if (wr_tx_data && !tx_full_reg) begin
      tx_buf_reg  <= WDATA;
      tx_full_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // transmit shifter
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      tx_busy_reg  <= 1'b0;
      tx_brk_reg   <= 1'b0;
      tx_shift_reg <= 14'h0000;
      tx_bit_reg   <= 4'h0;
      tx_tick_reg  <= 4'h0;
      txd_reg      <= 1'b1;
    end else if (tx_load) begin
      tx_busy_reg <= 1'b1;
      tx_brk_reg  <= send_break_reg;
      tx_bit_reg  <= 4'h0;
      tx_tick_reg <= 4'h0;
      txd_reg     <= 1'b0;                                   // start bit
      if (send_break_reg) begin
        tx_shift_reg <= 14'h2000;
      end else begin
        tx_shift_reg <= {4'h0, 1'b1, tx_buf_reg, 1'b0};
      end
    end else if (tx_done) begin
      tx_busy_reg <= 1'b0;
      txd_reg     <= 1'b1;
    end else if (tx_busy_reg && tick) begin
      tx_tick_reg <= tx_tick_reg + 4'h1;
      if (tx_tick_reg == sbsd_pkg::OVERSAMPLE_LAST) begin
        // next bit of the frame onto the line
        tx_bit_reg   <= tx_bit_reg + 4'h1;
        tx_shift_reg <= {1'b0, tx_shift_reg[13:1]};
        txd_reg      <= tx_shift_reg[1];
      end
    end
  end

  assign TXD = txd_reg;

  // ----------------------------------------------------------------
  // receive line synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rx_s1_reg   <= 1'b1;
      rx_s2_reg   <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_s1_reg   <= RXD;
      rx_s2_reg   <= rx_s1_reg;
      rx_prev_reg <= rx_s2_reg;
    end
  end

  assign rx_edge  = rx_s2_reg != rx_prev_reg;
  assign wake_hit = wake_en_reg && rx_edge && (wake_cnt_reg == sbsd_pkg::WAKE_EDGES - 2'h1);
  assign rx_done  = (rx_state_reg == RX_STOP) && tick && (rx_tick_reg == sbsd_pkg::OVERSAMPLE_LAST);

  // ----------------------------------------------------------------
  // receive control bits
  // ----------------------------------------------------------------
  // wake-up disarms itself after the second transition
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rx_en_reg    <= 1'b0;
      wake_en_reg  <= 1'b0;
      rate_det_reg <= 1'b0;
    end else begin
      if (WR && ADDR == sbsd_pkg::ADDR_RX_CTRL) begin
        rx_en_reg    <= WDATA[sbsd_pkg::RXC_RX_ENABLE];
        wake_en_reg  <= WDATA[sbsd_pkg::RXC_WAKE_EN];
        rate_det_reg <= WDATA[sbsd_pkg::RXC_RATE_DET];
      end
      if (wake_hit) begin
        wake_en_reg <= 1'b0;
      end
    end
  end

  // transition counter for the wake-up watch
  always_ff @(posedge MCLK) begin
    if (RST || !wake_en_reg) begin
      wake_cnt_reg <= 2'h0;
    end else if (rx_edge) begin
      wake_cnt_reg <= wake_cnt_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // receive state machine
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rx_state_reg <= RX_IDLE;
      rx_tick_reg  <= 4'h0;
      rx_bit_reg   <= 3'h0;
      rx_shift_reg <= 8'h00;
    end else begin
      unique case (rx_state_reg)
        RX_IDLE: begin
          // falling edge starts a frame unless the wake watch owns the line
          rx_tick_reg <= 4'h0;
          if (rx_en_reg && !wake_en_reg && rx_edge && !rx_s2_reg) begin
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == sbsd_pkg::MID_BIT) begin
              // glitch check in mid start bit
              rx_tick_reg  <= 4'h0;
              rx_bit_reg   <= 3'h0;
              rx_state_reg <= rx_s2_reg ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == sbsd_pkg::OVERSAMPLE_LAST) begin
              // sample in the middle of each data bit, lsb first
              rx_shift_reg <= {rx_s2_reg, rx_shift_reg[7:1]};
              rx_bit_reg   <= rx_bit_reg + 3'h1;
              if (rx_bit_reg == sbsd_pkg::DATA_LAST) begin
                rx_state_reg <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_done) begin
              rx_state_reg <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive data and flags
  // ----------------------------------------------------------------
  // a break lands here as zero data with framing error, flag set
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rx_data_reg <= 8'h00;
      rx_full_reg <= 1'b0;
      rx_framing_error_flag_reg <= 1'b0;
    end else if (rx_done) begin
      rx_data_reg <= rx_shift_reg;
      rx_full_reg <= 1'b1;
      rx_framing_error_flag_reg <= !rx_s2_reg;
    end else if (rd_rx_data) begin
      rx_full_reg <= 1'b0;
      rx_framing_error_flag_reg <= 1'b0;
    end
  end

  // wake event holds the receive flag until the data is read
  always_ff @(posedge MCLK) begin
    if (RST) begin
      wake_pend_reg <= 1'b0;
    end else if (wake_hit) begin
      wake_pend_reg <= 1'b1;
    end else if (rd_rx_data) begin
      wake_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign irq_set = {rx_done && !rx_s2_reg, rx_done || wake_hit, tx_load};

  // sticky bits, set wins over write-one-to-clear
  always_ff @(posedge MCLK) begin
    if (RST) begin
      irq_stat_reg <= '0;
    end else if (WR && ADDR == sbsd_pkg::ADDR_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~WDATA[IRQ_BITS_W-1:0]) | irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  // mask register
  always_ff @(posedge MCLK) begin
    if (RST) begin
      irq_mask_reg <= '0;
    end else if (WR && ADDR == sbsd_pkg::ADDR_IRQ_MASK) begin
      irq_mask_reg <= WDATA[IRQ_BITS_W-1:0];
    end
  end

  assign IRQ = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // read data valid in the cycle after the strobe, zero otherwise
  always_ff @(posedge MCLK) begin
    if (RST || !RD) begin
      RDATA <= 8'h00;
    end else begin
      unique case (ADDR)
        sbsd_pkg::ADDR_TX_CTRL: begin
          RDATA <= {4'h0, !tx_full_reg, !tx_busy_reg, tx_en_reg, send_break_reg};
        end
        sbsd_pkg::ADDR_RX_CTRL: begin
          RDATA <= {3'h0, rx_full_reg || wake_pend_reg, rx_framing_error_flag_reg,
                    rate_det_reg, wake_en_reg, rx_en_reg};
        end
        sbsd_pkg::ADDR_RX_DATA: begin
          RDATA <= rx_data_reg;
        end
        sbsd_pkg::ADDR_RATE: begin
          RDATA <= 8'(rate_reg);
        end
        sbsd_pkg::ADDR_IRQ_STAT: begin
          RDATA <= {5'h00, irq_stat_reg};
        end
        sbsd_pkg::ADDR_IRQ_MASK: begin
          RDATA <= {5'h00, irq_mask_reg};
        end
        default: begin
          RDATA <= 8'h00;                                    // write-only or unmapped
        end
      endcase
    end
  end

endmodule

//--- include/sbsd_pkg.sv
package sbsd_pkg;

  // ----------------------------------------------------------------
  // register map (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_TX_CTRL  = 3'h0;   // transmit_status_control
  localparam logic [2:0] ADDR_TX_DATA  = 3'h1;   // transmit_data_reg (write only)
  localparam logic [2:0] ADDR_RX_CTRL  = 3'h2;   // receive_status_control
  localparam logic [2:0] ADDR_RX_DATA  = 3'h3;   // receive_data_reg (read pops)
  localparam logic [2:0] ADDR_RATE     = 3'h4;   // bit_rate_generator divisor
  localparam logic [2:0] ADDR_IRQ_STAT = 3'h5;   // sticky events, write one to clear
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h6;   // interrupt enables

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TXC_SEND_BREAK = 0;             // send_break_ctl, auto cleared
  localparam int TXC_TX_ENABLE  = 1;             // transmit_enable_bit
  localparam int TXC_SHIFT_EMPT = 2;             // shift_empty_flag, read only
  localparam int TXC_TX_IRQ     = 3;             // transmit_irq_flag, read only
  localparam int RXC_RX_ENABLE  = 0;             // receiver enable
  localparam int RXC_WAKE_EN    = 1;             // auto wake-up, auto cleared
  localparam int RXC_RATE_DET   = 2;             // auto_rate_detect_enable
  localparam int RXC_FRAME_ERR  = 3;             // framing_error_flag, read only
  localparam int RXC_RX_IRQ     = 4;             // receive_irq_flag, read only
  localparam int IRQ_TX_EMPTY   = 0;             // transmit buffer emptied
  localparam int IRQ_RX_EVENT   = 1;             // byte or wake event received
  localparam int IRQ_FRAME_ERR  = 2;             // stop bit sampled low
  localparam int IRQ_BITS       = 3;

  // ----------------------------------------------------------------
  // reset values and framing counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RATE_RESET   = 8'h40;   // plain default divisor
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF; // sixteen ticks per bit
  localparam logic [3:0] MID_BIT      = 4'h7;    // start bit checked mid way
  localparam logic [3:0] NORMAL_BITS  = 4'hA;    // start, eight data, stop
  localparam logic [3:0] BREAK_BITS   = 4'hE;    // start, twelve zeros, stop
  localparam logic [2:0] DATA_LAST    = 3'h7;    // eighth data bit index
  localparam logic [1:0] WAKE_EDGES   = 2'h2;    // transitions watched on wake

endpackage

//--- verif/sbsd_node.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bus node: decodes the transmit line, drives the receive line
// ----------------------------------------------------------------
module sbsd_node #(
  parameter int BL = 16                  // clocks per bit, matches divisor 0
) (
  input  wire logic       clk,
  input  wire logic       txd,
  output logic            rxd,
  output logic            frm_ok,        // rises when a frame is decoded
  output logic            frm_brk,       // frame was a break
  output logic      [7:0] frm_val        // byte, or count of low bits
);
  logic [7:0] sh;                        // sampled data bits
  int         n;                         // low bits so far
  initial begin
    rxd    = 1'b1;
    frm_ok = 1'b0;
  end
  // mid-bit sampling of one frame
  always begin
    @(negedge txd);
    repeat (BL / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BL) @(posedge clk);
      sh[i] = txd;
    end
    repeat (BL) @(posedge clk);
    n = 9;
    while (!txd && sh == 8'h00 && n < 40) begin
      n++;
      repeat (BL) @(posedge clk);
    end
    frm_brk <= (n > 9);
    frm_val <= (n > 9) ? n[7:0] : sh;
    frm_ok  <= 1'b1;
    @(posedge clk);
    frm_ok  <= 1'b0;
  end
  // send bits lsb first at BL clocks per bit, then idle high
  task automatic send_bits(input logic [13:0] v, input int nb);
    for (int i = 0; i < nb; i++) begin
      rxd <= v[i];
      repeat (BL) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BL) @(posedge clk);
  endtask
endmodule

//--- verif/sbsd_top_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module sbsd_top_asserts #(
  parameter int RATE_W = 8               // divisor width
) (
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       RXD,
  input wire logic       TXD,
  input wire logic       IRQ
);
  logic [RATE_W-1:0] rate_m;             // divisor as written
  logic              ten_m;              // transmit enable as written
  logic [7:0]        msk_m;              // mask as written
  logic              seen;               // a frame has been sent
  int                lo_cnt;             // cycles of the low run
  int                hi_cnt;             // cycles of the high run
  int                bl;                 // clocks per bit
  assign bl = 16 * (int'(rate_m) + 1);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // mirror of software writes
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rate_m <= RATE_W'(sbsd_pkg::RATE_RESET);
      ten_m  <= 1'b0;
      msk_m  <= 8'h00;
    end else if (WR) begin
      if (ADDR == sbsd_pkg::ADDR_RATE) rate_m <= WDATA[RATE_W-1:0];
      if (ADDR == sbsd_pkg::ADDR_TX_CTRL) ten_m <= WDATA[sbsd_pkg::TXC_TX_ENABLE];
      if (ADDR == sbsd_pkg::ADDR_IRQ_MASK) msk_m <= WDATA;
    end
  end
  // run lengths of the transmit line
  always_ff @(posedge MCLK) begin
    if (RST) begin
      lo_cnt <= 0;
      hi_cnt <= 0;
      seen   <= 1'b0;
    end else begin
      lo_cnt <= TXD ? 0 : lo_cnt + 1;
      hi_cnt <= TXD ? hi_cnt + 1 : 0;
      if (!TXD) seen <= 1'b1;
    end
  end
  sequence s_idle_write;
    WR && ADDR == sbsd_pkg::ADDR_TX_DATA && ten_m && hi_cnt >= 10 * bl;
  endsequence
  sequence s_start_bit;
    ##1 TXD ##1 !TXD;
  endsequence
  a_break_low_max: assert property (lo_cnt <= 13 * bl)
    else $error("low run longer than a break");
  a_bit_min_low: assert property ($rose(TXD) |-> lo_cnt >= bl - (int'(rate_m) + 1))
    else $error("low bit too short");
  a_bit_min_high: assert property ($fell(TXD) && seen |-> hi_cnt >= bl - (int'(rate_m) + 1))
    else $error("high bit too short");
  a_write_starts_tx: assert property (s_idle_write |-> s_start_bit)
    else $error("write did not start a frame");
  a_enable_reads: assert property (RD && ADDR == sbsd_pkg::ADDR_TX_CTRL |=> RDATA[1] == ten_m)
    else $error("transmit enable reads wrong");
  a_rate_reads: assert property (RD && ADDR == sbsd_pkg::ADDR_RATE |=> RDATA == 8'(rate_m))
    else $error("divisor reads wrong");
  a_irq_masked: assert property (msk_m == 8'h00 |-> !IRQ)
    else $error("interrupt with mask clear");
  a_unmapped_zero: assert property (RD && ADDR == 3'h7 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside read cycle");
  a_txd_reset: assert property (disable iff (1'b0) RST |=> TXD && !IRQ)
    else $error("line or interrupt active in reset");
endmodule

bind sbsd_top sbsd_top_asserts #(.RATE_W(RATE_W)) u_sbsd_top_asserts (.MCLK(MCLK), .RST(RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RXD(RXD), .TXD(TXD), .IRQ(IRQ));

//--- verif/sbsd_top_tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// self-checking bench
// ----------------------------------------------------------------
module sbsd_top_tb;
  logic       mclk = 1'b0;               // 10 MHz
  logic       rst = 1'b1;                // synchronous reset
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr_s = 1'b0;               // write strobe
  logic       rd_s = 1'b0;               // read strobe
  logic       rd_dly = 1'b0;             // read taken at last edge
  logic [7:0] rdata;
  logic       rxd;
  logic       txd;
  logic       irq;
  logic       f_ok;
  logic       f_brk;
  logic [7:0] f_val;
  logic [7:0] exp_q[$];                  // expected read data
  logic [7:0] msk_q[$];                  // bits that matter
  logic [8:0] frm_q[$];                  // expected frames
  logic [7:0] v;
  logic [7:0] b;
  int         fails = 0;
  int         n_compared = 0;
  int         seed = 20;
  always #50 mclk = ~mclk;
  sbsd_top u_sbsd_top (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .RXD(rxd), .TXD(txd), .IRQ(irq));
  sbsd_node u_sbsd_node (.clk(mclk), .txd(txd), .rxd(rxd), .frm_ok(f_ok), .frm_brk(f_brk), .frm_val(f_val));
  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge mclk);
    wr_s  <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m, output logic [7:0] d);
    exp_q.push_back(e);
    msk_q.push_back(m);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    @(negedge mclk);
    d = rdata;
    @(posedge mclk);
  endtask
  // wait until the transmit buffer has room
  task automatic wait_room();
    for (int i = 0; i < 400; i++) begin
      rd(sbsd_pkg::ADDR_TX_CTRL, 8'h00, 8'h00, v);
      if (v[3] === 1'b1) return;
    end
    fails++;
    test_done();
  endtask
  // wait until every expected frame has arrived
  task automatic wait_frames();
    for (int i = 0; i < 8000; i++) begin
      if (frm_q.size() == 0) begin
        // let the stop bit of the last frame finish on the line
        repeat (16) @(posedge mclk);
        return;
      end
      @(posedge mclk);
    end
    fails++;
    test_done();
  endtask
  // read data checker
  always @(posedge mclk) rd_dly <= rd_s;
  always @(negedge mclk) begin
    if (rd_dly === 1'b1) begin
      chk("rdata", {1'b0, rdata & msk_q[0]}, {1'b0, exp_q[0] & msk_q[0]});
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  // frame checker
  always @(posedge f_ok) begin
    chk("frame", {f_brk, f_val}, frm_q.pop_front());
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // reset values
    rd(sbsd_pkg::ADDR_TX_CTRL, 8'h0C, 8'hFF, v);
    rd(sbsd_pkg::ADDR_RX_CTRL, 8'h00, 8'hFF, v);
    rd(sbsd_pkg::ADDR_RATE, 8'h40, 8'hFF, v);
    rd(sbsd_pkg::ADDR_IRQ_MASK, 8'h00, 8'hFF, v);
    rd(3'h7, 8'h00, 8'hFF, v);
    wr(sbsd_pkg::ADDR_RATE, 8'h00);
    wr(sbsd_pkg::ADDR_IRQ_MASK, 8'h07);
    wr(sbsd_pkg::ADDR_IRQ_STAT, 8'h07);
    wr(sbsd_pkg::ADDR_RX_CTRL, 8'h01);
    // break then sync byte
    wr(sbsd_pkg::ADDR_TX_CTRL, 8'h03);
    repeat (200) @(posedge mclk);
    frm_q.push_back(9'h10D);
    frm_q.push_back(9'h055);
    b = $random(seed);
    wr(sbsd_pkg::ADDR_TX_DATA, b | 8'h01);
    wait_room();
    wr(sbsd_pkg::ADDR_TX_DATA, 8'h55);
    rd(sbsd_pkg::ADDR_TX_CTRL, 8'h03, 8'hFF, v);
    wait_frames();
    rd(sbsd_pkg::ADDR_TX_CTRL, 8'h0E, 8'hFF, v);
    rd(sbsd_pkg::ADDR_IRQ_STAT, 8'h01, 8'h01, v);
    chk("irq", {8'h00, irq}, 9'h001);
    // two normal random bytes, second buffered
    for (int i = 0; i < 2; i++) begin
      b = $random(seed);
      frm_q.push_back({1'b0, b});
      wr(sbsd_pkg::ADDR_TX_DATA, b);
      wait_room();
    end
    wait_frames();
    wr(sbsd_pkg::ADDR_IRQ_STAT, 8'h07);
    chk("irq", {8'h00, irq}, 9'h000);
    // received break
    u_sbsd_node.send_bits(14'h0000, 13);
    rd(sbsd_pkg::ADDR_RX_CTRL, 8'h18, 8'h18, v);
    rd(sbsd_pkg::ADDR_IRQ_STAT, 8'h06, 8'h06, v);
    rd(sbsd_pkg::ADDR_RX_DATA, 8'h00, 8'hFF, v);
    wr(sbsd_pkg::ADDR_IRQ_MASK, 8'h00);
    chk("irq", {8'h00, irq}, 9'h000);
    wr(sbsd_pkg::ADDR_IRQ_MASK, 8'h07);
    chk("irq", {8'h00, irq}, 9'h001);
    wr(sbsd_pkg::ADDR_IRQ_STAT, 8'h07);
    chk("irq", {8'h00, irq}, 9'h000);
    // wake-up on break, then a byte
    wr(sbsd_pkg::ADDR_RX_CTRL, 8'h07);
    u_sbsd_node.send_bits(14'h0000, 13);
    rd(sbsd_pkg::ADDR_RX_CTRL, 8'h15, 8'hFF, v);
    rd(sbsd_pkg::ADDR_RX_DATA, 8'h00, 8'h00, v);
    b = $random(seed);
    u_sbsd_node.send_bits({4'h0, 1'b1, b, 1'b0}, 10);
    rd(sbsd_pkg::ADDR_RX_CTRL, 8'h15, 8'hFF, v);
    rd(sbsd_pkg::ADDR_RX_DATA, b, 8'hFF, v);
    test_done();
  end
endmodule
